// file: verilog/tbp_pkg.sv
/*
  Shared constants for the 10 Mb/s twisted-pair coding and link block:
  clock rate, line timing, Manchester half-bit codes and state encodings.
  Assumes a single 10 MHz system clock, so one bit time is one clock cycle.
*/
package tbp_pkg;
  // System clock and line timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BIT_NS = 100;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int BIT_CYCLES = BIT_NS / CLK_NS;
  localparam int NIBBLE_HZ = 2_500_000;
  localparam int NIB_DIV = CLK_HZ / NIBBLE_HZ;
  localparam int NLP_PERIOD_MS = 16;
  localparam int NLP_PERIOD_CYCLES = NLP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int LINK_LOSS_MS = 82;
  localparam int LINK_LOSS_CYCLES = LINK_LOSS_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 20;

  // Data path widths and counts
  localparam int NIB_W = 4;
  localparam int LOCK_BITS = 3;
  localparam int NLP_QUALIFY = 8;
  localparam int EOP_IDLE_BITS = 2;

  // Half-bit pairs on the line: bit 1 is the first half, bit 0 the second
  localparam logic [1:0] MANCH_ONE = 2'h2;
  localparam logic [1:0] MANCH_ZERO = 2'h1;
  localparam logic [1:0] LINE_HIGH = 2'h3;
  localparam logic [1:0] LINE_OFF = 2'h0;

  // Reset values
  localparam logic STRICT_INHIBIT_RST = 1'h0;
  localparam logic LINK_STATUS_RST = 1'h0;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_DATA = 3'h2,
    TX_EOP = 3'h4
  } tbp_tx_e;

  typedef enum logic [1:0] {
    LINK_DOWN = 2'h1,
    LINK_UP = 2'h2
  } tbp_link_e;
endpackage : tbp_pkg

// file: verilog/tbp_stream_if.sv
/*
  Valid/ready stream carrier between the coding link and its receive buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tbp_stream_if #(
  parameter int W = 4
);
  logic fillValid;
  logic fillReady;
  logic [W-1:0] fillData;
  logic drainValid;
  logic drainReady;
  logic [W-1:0] drainData;

  modport buffer(input fillValid, input fillData, input drainReady,
                 output fillReady, output drainValid, output drainData);
  modport user(output fillValid, output fillData, output drainReady,
               input fillReady, input drainValid, input drainData);
endinterface : tbp_stream_if

// file: verilog/tbp_rx_buf.sv
/*
  Small receive FIFO with valid and ready on both sides, storage in flops.
  Assumes DEPTH is a power of two, at least two.
*/
`timescale 1ns/1ps
module tbp_rx_buf #(
  parameter int W = 4,
  parameter int DEPTH = 2
)(
  input wire logic clk,
  input wire logic rst_b,
  tbp_stream_if.buffer bus
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty when the indices meet
  assign empty = (wrPtr_reg == rdPtr_reg);
  assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign bus.fillReady = !full;
  assign bus.drainValid = !empty;
  assign bus.drainData = mem_reg[rdPtr_reg[AW-1:0]];
  assign push = bus.fillValid && !full;
  assign pop = bus.drainReady && !empty;

  // Pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  // One write enable per entry; data needs no reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && (wrPtr_reg[AW-1:0] == AW'(i))) begin
        mem_reg[i] <= bus.fillData;
      end
    end
  end
endmodule : tbp_rx_buf

// file: verilog/tbp_coding_link.sv
/*
  Digital side of a 10 Mb/s twisted-pair PHY: Manchester encode and decode,
  nibble clock, link pulses, link monitor, carrier sense and collision.
  Assumes the analog front end serialises the two half-bit codes of txLine
  within each 100 ns cycle, and on receive presents a bit strobe, an activity
  level (data only, not link pulses), a link pulse level and the two half-bit
  samples, all asynchronous to clk and stable around the strobe edge.
*/
// Contract
// - One is high then low; zero opposite
// - Transmit accepts nibbles or serial bits
// - Decode Manchester to NRZ, serial or nibble
// - Nibble interface gets a 2.5 MHz clock
// - Recovery starts at preamble, tracks during receive
// - Idle transmitter sends link pulse every 16 ms
// - Link pulses during receive never cause collision
// - One link status bit for both views
// - Link status latches low on any drop
// - More than seven link pulses validate link
// - Strict mode needs data plus end idle
// - Silence beyond 81-83 ms invalidates link
// - Valid data needs three locked bit times
// - Data-driven validation waits for packet end
// - Going valid does not set status bit
// - Strict inhibit resets to zero, one disables
// - Every transmitted packet ends with idle
// - Half duplex: carrier on transmit or receive
// - Full duplex or repeater: carrier on receive
// - Collision in half duplex only, never full
// - Bit time 100 ns, half-bit 50 ns
`timescale 1ns/1ps
module tbp_coding_link import tbp_pkg::*; #(
  parameter int NLP_CYCLES = NLP_PERIOD_CYCLES,
  parameter int LOSS_CYCLES = LINK_LOSS_CYCLES,
  parameter int BUF_DEPTH = 2
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serialMode,
  input wire logic halfDuplex,
  input wire logic repeaterMode,
  input wire logic cfgWrite,
  input wire logic cfgStrictInhibit,
  input wire logic statusRead,
  input wire logic txEn,
  input wire logic [NIB_W-1:0] txData,
  output logic txClk,
  output logic [1:0] txLine,
  input wire logic rxClkPin,
  input wire logic rxActivePin,
  input wire logic rxPulsePin,
  input wire logic [1:0] rxHalves,
  input wire logic rxReady,
  output logic rxDv,
  output logic [NIB_W-1:0] rxData,
  output logic rxOverrun,
  output logic crs,
  output logic col,
  output logic linkStatus,
  output logic strictInhibit
);
  tbp_stream_if #(.W(NIB_W)) strm();

  tbp_rx_buf #(.W(NIB_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .bus(strm.buffer)
  );

  tbp_tx_e txState_reg;
  tbp_link_e linkState_reg;
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic prevClk_reg;
  logic prevPulse_reg;
  logic prevBusy_reg;
  logic [1:0] divCnt_reg;
  logic [TIMER_W-1:0] nlpTimer_reg;
  logic [TIMER_W-1:0] lossCnt_reg;
  logic [3:0] nlpSeen_reg;
  logic [1:0] lockCnt_reg;
  logic sawData_reg;
  logic lastIdle_reg;
  logic [NIB_W-1:0] txSh_reg;
  logic [1:0] txBitCnt_reg;
  logic [1:0] eopCnt_reg;
  logic [NIB_W-1:0] asm_reg;
  logic [1:0] asmCnt_reg;
  logic [NIB_W-1:0] pend_reg;
  logic pendValid_reg;
  logic [1:0] halvesS;
  logic rxClkS;
  logic rxBusy;
  logic pulseS;
  logic rxEdge;
  logic nlpEvent;
  logic rxEnd;
  logic rxLocked;
  logic symValid;
  logic bitVal;
  logic takeBit;
  logic wordFull;
  logic [NIB_W-1:0] rxWord;
  logic qualEnd;
  logic refresh;
  logic linkUp;
  logic goDown;
  logic nlpTick;
  logic takeNow;
  logic lastBit;
  logic [NIB_W-1:0] txWord;
  logic txBusy;

  // Two-flop synchronisers for every line-side input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {rxClkPin, rxActivePin, rxPulsePin, rxHalves};
      sync_reg <= meta_reg;
    end
  end

  assign rxClkS = sync_reg[4];
  assign rxBusy = sync_reg[3];
  assign pulseS = sync_reg[2];
  assign halvesS = sync_reg[1:0];

  // Edge detectors look only at the second synchroniser stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevClk_reg <= 1'b0;
      prevPulse_reg <= 1'b0;
      prevBusy_reg <= 1'b0;
    end else begin
      prevClk_reg <= rxClkS;
      prevPulse_reg <= pulseS;
      prevBusy_reg <= rxBusy;
    end
  end

  assign rxEdge = rxClkS && !prevClk_reg;
  assign nlpEvent = pulseS && !prevPulse_reg;
  assign rxEnd = !rxBusy && prevBusy_reg;

  // Strict qualification inhibit, written by management
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strictInhibit <= STRICT_INHIBIT_RST;
    end else if (cfgWrite) begin
      strictInhibit <= cfgStrictInhibit;
    end
  end

  // Nibble clock divider; txClk is a flop bit, so it is glitch free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_reg <= '0;
    end else if (divCnt_reg == 2'(NIB_DIV - 1)) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_reg + 1'b1;
    end
  end

  assign txClk = divCnt_reg[1];

  // Free-running link pulse timer; a pulse due during a packet is skipped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nlpTimer_reg <= '0;
    end else if (nlpTick) begin
      nlpTimer_reg <= '0;
    end else begin
      nlpTimer_reg <= nlpTimer_reg + 1'b1;
    end
  end

  assign nlpTick = (nlpTimer_reg == TIMER_W'(NLP_CYCLES - 1));

  // Transmit word intake: nibble on the divider phase, or one bit a cycle
  assign takeNow = serialMode || (divCnt_reg == 2'h0);
  assign txWord = serialMode ? {{(NIB_W-1){1'b0}}, txData[0]} : txData;
  assign lastBit = serialMode || (txBitCnt_reg == 2'(NIB_W - 1));
  assign txBusy = (txState_reg == TX_DATA);

  // Transmit sequencer: data bits then end-of-packet idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txState_reg <= TX_IDLE;
      txSh_reg <= '0;
      txBitCnt_reg <= '0;
      eopCnt_reg <= '0;
    end else begin
      unique case (txState_reg)
        TX_IDLE: begin
          if (txEn && takeNow) begin
            txSh_reg <= txWord;
            txBitCnt_reg <= '0;
            txState_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (lastBit && txEn && takeNow) begin
            txSh_reg <= txWord;
            txBitCnt_reg <= '0;
          end else if (lastBit) begin
            eopCnt_reg <= '0;
            txState_reg <= TX_EOP;
          end else begin
            txSh_reg <= {1'b0, txSh_reg[NIB_W-1:1]};
            txBitCnt_reg <= txBitCnt_reg + 1'b1;
          end
        end
        TX_EOP: begin
          if (eopCnt_reg == 2'(EOP_IDLE_BITS - 1)) begin
            txState_reg <= TX_IDLE;
          end else begin
            eopCnt_reg <= eopCnt_reg + 1'b1;
          end
        end
        default: begin
          txState_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Line drive: one bit time per cycle, both halves sent together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txLine <= LINE_OFF;
    end else if (txState_reg == TX_DATA) begin
      txLine <= txSh_reg[0] ? MANCH_ONE : MANCH_ZERO;
    end else if (txState_reg == TX_EOP) begin
      txLine <= LINE_HIGH;
    end else if (nlpTick) begin
      txLine <= LINE_HIGH;
    end else begin
      txLine <= LINE_OFF;
    end
  end

  // Clock recovery: lock counts consecutive good symbols from the preamble
  assign symValid = (halvesS == MANCH_ONE) || (halvesS == MANCH_ZERO);
  assign rxLocked = (lockCnt_reg == 2'(LOCK_BITS));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockCnt_reg <= '0;
    end else if (!rxBusy) begin
      lockCnt_reg <= '0;
    end else if (rxEdge && !symValid) begin
      lockCnt_reg <= '0;
    end else if (rxEdge && !rxLocked) begin
      lockCnt_reg <= lockCnt_reg + 1'b1;
    end
  end

  // Packet bookkeeping for link qualification
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sawData_reg <= 1'b0;
      lastIdle_reg <= 1'b0;
    end else begin
      if (rxEnd) begin
        sawData_reg <= 1'b0;
      end else if (rxBusy && rxLocked) begin
        sawData_reg <= 1'b1;
      end
      if (rxEdge && rxBusy) begin
        lastIdle_reg <= (halvesS == LINE_HIGH);
      end
    end
  end

  assign qualEnd = rxEnd && sawData_reg && (strictInhibit || lastIdle_reg);

  // Decoder: NRZ bits shift in LSB first
  assign bitVal = (halvesS == MANCH_ONE);
  assign takeBit = rxEdge && rxBusy && rxLocked && symValid;
  assign wordFull = serialMode || (asmCnt_reg == 2'(NIB_W - 1));
  assign rxWord = serialMode ? {{(NIB_W-1){1'b0}}, bitVal} : {bitVal, asm_reg[NIB_W-1:1]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      asm_reg <= '0;
      asmCnt_reg <= '0;
    end else if (!rxBusy) begin
      asmCnt_reg <= '0;
    end else if (takeBit) begin
      asm_reg <= {bitVal, asm_reg[NIB_W-1:1]};
      asmCnt_reg <= wordFull ? 2'h0 : asmCnt_reg + 1'b1;
    end
  end

  // Holding stage in front of the buffer; the line cannot be stalled, so a
  // word still waiting when the next completes is replaced and flagged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= '0;
      pendValid_reg <= 1'b0;
      rxOverrun <= 1'b0;
    end else begin
      rxOverrun <= 1'b0;
      if (takeBit && wordFull) begin
        pend_reg <= rxWord;
        pendValid_reg <= 1'b1;
        rxOverrun <= pendValid_reg && !strm.fillReady;
      end else if (strm.fillReady) begin
        pendValid_reg <= 1'b0;
      end
    end
  end

  assign strm.fillValid = pendValid_reg;
  assign strm.fillData = pend_reg;
  assign strm.drainReady = rxReady;
  assign rxDv = strm.drainValid;
  assign rxData = strm.drainData;

  // Link monitor
  assign linkUp = (linkState_reg == LINK_UP);
  assign refresh = nlpEvent || qualEnd || (strictInhibit && rxLocked);
  assign goDown = linkUp && !refresh && (lossCnt_reg == TIMER_W'(LOSS_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkState_reg <= LINK_DOWN;
      nlpSeen_reg <= '0;
      lossCnt_reg <= '0;
    end else begin
      unique case (linkState_reg)
        LINK_DOWN: begin
          lossCnt_reg <= '0;
          if (qualEnd || (nlpSeen_reg == 4'(NLP_QUALIFY) && !rxBusy)) begin
            nlpSeen_reg <= '0;
            linkState_reg <= LINK_UP;
          end else if (nlpEvent && nlpSeen_reg != 4'(NLP_QUALIFY)) begin
            nlpSeen_reg <= nlpSeen_reg + 1'b1;
          end
        end
        LINK_UP: begin
          if (refresh) begin
            lossCnt_reg <= '0;
          end else if (goDown) begin
            lossCnt_reg <= '0;
            linkState_reg <= LINK_DOWN;
          end else begin
            lossCnt_reg <= lossCnt_reg + 1'b1;
          end
        end
        default: begin
          linkState_reg <= LINK_DOWN;
        end
      endcase
    end
  end

  // Latched-low status: a drop beats a read in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkStatus <= LINK_STATUS_RST;
    end else if (goDown) begin
      linkStatus <= 1'b0;
    end else if (statusRead) begin
      linkStatus <= linkUp;
    end
  end

  // Carrier sense and collision; received link pulses never reach rxBusy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      crs <= (halfDuplex && !repeaterMode) ? (txBusy || rxBusy) : rxBusy;
      col <= halfDuplex && txBusy && rxBusy;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_enter_eop;
    (txState_reg == TX_DATA) ##1 (txState_reg == TX_EOP);
  endsequence

  property p_manch_one;
    (txState_reg == TX_DATA) && txSh_reg[0] |=> (txLine == MANCH_ONE);
  endproperty
  a_p_manch_one: assert property (p_manch_one) else $error("one not sent high then low");

  property p_eop_idle;
    s_enter_eop |=> (txLine == LINE_HIGH) [*2];
  endproperty
  a_p_eop_idle: assert property (p_eop_idle) else $error("end idle missing after packet");

  property p_nib_clk;
    $rose(txClk) |=> txClk ##1 !txClk ##1 !txClk ##1 txClk;
  endproperty
  a_p_nib_clk: assert property (p_nib_clk) else $error("nibble clock not four cycles");

  property p_nlp;
    nlpTick && (txState_reg == TX_IDLE) |=> (txLine == LINE_HIGH);
  endproperty
  a_p_nlp: assert property (p_nlp) else $error("link pulse not sent when due");

  property p_latch_low;
    $fell(linkUp) |-> !linkStatus ##1 (!linkStatus || $past(statusRead));
  endproperty
  a_p_latch_low: assert property (p_latch_low) else $error("status not cleared on drop");

  property p_no_auto_set;
    $rose(linkUp) && !statusRead |=> !linkStatus;
  endproperty
  a_p_no_auto_set: assert property (p_no_auto_set) else $error("status set by link coming up");

  property p_reload;
    statusRead && !goDown |=> (linkStatus == $past(linkUp));
  endproperty
  a_p_reload: assert property (p_reload) else $error("read did not reload status");

  property p_nlp_qualify;
    !linkUp && (nlpSeen_reg == 4'(NLP_QUALIFY)) && !rxBusy |=> linkUp;
  endproperty
  a_p_nlp_qualify: assert property (p_nlp_qualify) else $error("link not up after pulses");

  property p_full_crs;
    (!halfDuplex || repeaterMode) && !rxBusy |=> !crs;
  endproperty
  a_p_full_crs: assert property (p_full_crs) else $error("carrier without receive");

  property p_half_crs;
    halfDuplex && !repeaterMode && txBusy |=> crs;
  endproperty
  a_p_half_crs: assert property (p_half_crs) else $error("carrier missing on transmit");

  property p_full_col;
    !halfDuplex |=> !col;
  endproperty
  a_p_full_col: assert property (p_full_col) else $error("collision in full duplex");

  property p_loss;
    goDown |=> !linkUp && !linkStatus;
  endproperty
  a_p_loss: assert property (p_loss) else $error("link kept after silence");
endmodule : tbp_coding_link

// file: testbench/tbp_line_partner.sv
/*
  Line-side partner: strobe, activity, link pulse and half-bit pins.
  Assumes one task runs at a time; strobe period 800 ns.
*/
`timescale 1ns/1ps
module tbp_line_partner (
  output logic rxClkPin,
  output logic rxActivePin,
  output logic rxPulsePin,
  output logic [1:0] rxHalves
);
  import tbp_pkg::*;
  logic [1:0] lastSym;
  // Quiet line: the strobe stands still outside frames
  initial begin
    rxClkPin = 1'h0;
    rxActivePin = 1'h0;
    rxPulsePin = 1'h0;
    rxHalves = 2'h0;
    lastSym = 2'h0;
  end
  // Halves settle half a period before the strobe rises
  task automatic sym(input logic [1:0] h);
    rxHalves = h;
    lastSym = h;
    #400 rxClkPin = 1'h1;
    #400 rxClkPin = 1'h0;
  endtask : sym
  // Pulses 2 us apart, well inside the loss time
  task automatic pulses(input int n);
    repeat (n) begin
      rxPulsePin = 1'h1;
      #300 rxPulsePin = 1'h0;
      #1700;
    end
  endtask : pulses
  // Three lock symbols, eight data bits low first, optional end idle
  task automatic packet(input logic [7:0] d, input bit idleEnd);
    rxActivePin = 1'h1;
    sym(MANCH_ONE);
    sym(MANCH_ZERO);
    sym(MANCH_ONE);
    for (int i = 0; i < 8; i++) begin
      sym(d[i] ? MANCH_ONE : MANCH_ZERO);
    end
    if (idleEnd) begin
      sym(LINE_HIGH);
    end
    #400 rxActivePin = 1'h0;
    // Released line shows the inverse, never the last value
    rxHalves = ~lastSym;
  endtask : packet
endmodule : tbp_line_partner

// file: testbench/tb.sv
/*
  Self-checking bench: transmit coding, receive path through the buffer,
  link monitor and carrier flags. Assumes shortened link timers.
*/
`timescale 1ns/1ps
module tb;
  import tbp_pkg::*;
  localparam int NLP = 64;
  localparam int LOSS = 400;
  logic clk, rst_b, serialMode, halfDuplex, repeaterMode, cfgWrite;
  logic cfgStrictInhibit, statusRead, txEn, rxReady, rxClkPin;
  logic rxActivePin, rxPulsePin, txClk, rxDv, rxOverrun, crs, col;
  logic linkStatus, strictInhibit, crsSeen, colSeen;
  logic [NIB_W-1:0] txData, rxData;
  logic [1:0] txLine, rxHalves;
  logic [31:0] seed;
  logic [3:0] rxq[$];
  int errors, compares, k;
  int ovCount = 0;

  tbp_coding_link #(.NLP_CYCLES(NLP), .LOSS_CYCLES(LOSS), .BUF_DEPTH(2)) tbp_coding_link_inst (
    .clk(clk), .rst_b(rst_b), .serialMode(serialMode), .halfDuplex(halfDuplex),
    .repeaterMode(repeaterMode), .cfgWrite(cfgWrite), .cfgStrictInhibit(cfgStrictInhibit),
    .statusRead(statusRead), .txEn(txEn), .txData(txData), .txClk(txClk), .txLine(txLine),
    .rxClkPin(rxClkPin), .rxActivePin(rxActivePin), .rxPulsePin(rxPulsePin),
    .rxHalves(rxHalves), .rxReady(rxReady), .rxDv(rxDv), .rxData(rxData),
    .rxOverrun(rxOverrun), .crs(crs), .col(col), .linkStatus(linkStatus),
    .strictInhibit(strictInhibit));
  tbp_line_partner tbp_line_partner_inst (
    .rxClkPin(rxClkPin), .rxActivePin(rxActivePin), .rxPulsePin(rxPulsePin),
    .rxHalves(rxHalves));

  // 10 MHz system clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Overrun is a one-cycle pulse; count it mid-cycle, away from the edge that launches it
  always @(negedge clk) begin
    ovCount <= ovCount + ((rxOverrun === 1'h1) ? 1 : 0);
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Inputs change 1 ns after the edge; carrier flags are accumulated
  task automatic tick();
    @(posedge clk);
    #1;
    crsSeen = crsSeen | crs;
    colSeen = colSeen | col;
  endtask : tick

  // Align to nibble phase zero, send n bits; the line lags the intake edge by one
  task automatic tx_run(input logic [15:0] bits, input int n);
    logic [1:0] exp;
    logic prev;
    prev = 1'h0;
    while (!(prev === 1'h1 && txClk === 1'h0)) begin
      prev = txClk;
      tick();
    end
    for (int i = 0; i < n + 3; i++) begin
      txEn = (i < n);
      txData = serialMode ? {3'h0, bits[i]} : bits[(i / 4) * 4 +: 4];
      tick();
      if (i >= 1) begin
        exp = (i - 1 >= n) ? LINE_HIGH : (bits[i - 1] ? MANCH_ONE : MANCH_ZERO);
        check(8'(txLine), 8'(exp));
      end
    end
  endtask : tx_run

  // Management read; afterwards the bit holds the present link state
  task automatic rd(input logic exp);
    statusRead = 1'h1;
    tick();
    statusRead = 1'h0;
    tick();
    check(8'(linkStatus), 8'(exp));
  endtask : rd

  task automatic rx_pkt(input bit idleEnd);
    logic [7:0] d;
    d = 8'(xs());
    rxq.push_back(d[3:0]);
    rxq.push_back(d[7:4]);
    tbp_line_partner_inst.packet(d, idleEnd);
  endtask : rx_pkt

  // Accept pending words in order; the receiver stalled until now
  task automatic drain();
    rxReady = 1'h1;
    for (int j = 0; j < 100 && rxq.size() > 0; j++) begin
      if (rxDv === 1'h1) begin
        check(8'(rxData), 8'(rxq.pop_front()));
      end
      tick();
    end
    rxReady = 1'h0;
    check(8'(rxq.size()), 8'h0);
    tick();
    check(8'(rxDv), 8'h0);
  endtask : drain

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #2_000_000;
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    seed = 32'ha67e;
    errors = 0;
    compares = 0;
    {rst_b, serialMode, repeaterMode, cfgWrite, cfgStrictInhibit} = 5'h0;
    {statusRead, txEn, rxReady, crsSeen, colSeen} = 5'h0;
    halfDuplex = 1'h1;
    txData = 4'h0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'h1;
    check(8'(linkStatus), 8'h0);
    check(8'(strictInhibit), 8'h0);
    check(8'(txLine), 8'(LINE_OFF));
    // Two nibbles, half duplex: carrier from transmit, no collision
    tx_run(16'(xs()), 8);
    check(8'(crsSeen), 8'h1);
    check(8'(colSeen), 8'h0);
    // Nibble clock: high two cycles, low two
    k = 0;
    for (int j = 0; j < 8; j++) begin
      tick();
      k += (txClk === 1'h1);
    end
    check(8'(k), 8'h4);
    // Serial bits in repeater mode: transmit alone raises no carrier
    serialMode = 1'h1;
    repeaterMode = 1'h1;
    crsSeen = 1'h0;
    tx_run(16'(xs()), 12);
    check(8'(crsSeen), 8'h0);
    serialMode = 1'h0;
    repeaterMode = 1'h0;
    // Idle link pulse spacing
    repeat (10) tick();
    for (k = 0; k < 200 && txLine !== LINE_HIGH; k++) tick();
    tick();
    for (k = 1; k < 200 && txLine !== LINE_HIGH; k++) tick();
    check(8'(k), 8'(NLP));
    // Seven pulses are not enough, the eighth validates
    tbp_line_partner_inst.pulses(7);
    rd(1'h0);
    tbp_line_partner_inst.pulses(1);
    repeat (6) tick();
    check(8'(linkStatus), 8'h0);
    rd(1'h1);
    repeat (LOSS - 100) tick();
    check(8'(linkStatus), 8'h1);
    repeat (150) tick();
    check(8'(linkStatus), 8'h0);
    rd(1'h0);
    // Strict: data without end idle, full duplex, transmit overlaps
    halfDuplex = 1'h0;
    {crsSeen, colSeen} = 2'h0;
    fork
      rx_pkt(1'b0);
      begin
        repeat (30) tick();
        tx_run(16'(xs()), 8);
      end
    join
    check(8'(crsSeen), 8'h1);
    check(8'(colSeen), 8'h0);
    drain();
    rd(1'h0);
    // Strict: data with end idle, half duplex, transmit overlaps
    halfDuplex = 1'h1;
    fork
      rx_pkt(1'b1);
      begin
        repeat (30) tick();
        tx_run(16'(xs()), 8);
      end
    join
    check(8'(colSeen), 8'h1);
    drain();
    rd(1'h1);
    // Inhibit strict mode, let the link drop, then plain data
    cfgWrite = 1'h1;
    cfgStrictInhibit = 1'h1;
    tick();
    cfgWrite = 1'h0;
    tick();
    check(8'(strictInhibit), 8'h1);
    repeat (LOSS + 60) tick();
    rd(1'h0);
    colSeen = 1'h0;
    fork
      rx_pkt(1'b0);
      begin
        repeat (50) tick();
        rd(1'h0);
      end
    join
    check(8'(colSeen), 8'h0);
    drain();
    rd(1'h1);
    // Receiver stalled over two packets: the fourth nibble replaces the third
    check(8'(ovCount), 8'h0);
    rx_pkt(1'b0);
    repeat (10) tick();
    rx_pkt(1'b0);
    repeat (10) tick();
    check(8'(ovCount), 8'h1);
    rxq.delete(2);
    drain();
    print_verdict();
  end
endmodule : tb
